// file: logic/cam_select_pkg.sv
// Shared constants and types for the CAM select and validity pair
package cam_select_pkg;
  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int DATA_W  = 32;
  localparam int DEPTH   = 16;
  localparam int ADDR_W  = 4;
  localparam int PAGE_W  = 4;
  // ----------------------------------------------------------------
  // Select register fields
  // ----------------------------------------------------------------
  localparam int SEL_DISABLE_BIT = 8;
  localparam logic [31:0] SEL_RESET = 32'h0000_0100;
  localparam logic [31:0] SEL_MASK  = 32'h0000_010F;
  // ----------------------------------------------------------------
  // Instruction codes and fields
  // ----------------------------------------------------------------
  localparam int READ_TYPE_BIT = 12;
  localparam int MASK_SEL_LSB  = 6;
  localparam logic [15:0] OP_WRITE_ADDR    = 16'h0000;
  localparam logic [15:0] OP_WRITE_NEXT    = 16'h0001;
  localparam logic [15:0] OP_WRITE_ADDRREG = 16'h0004;
  localparam logic [15:0] OP_WRITE_SELECT  = 16'h0008;
  localparam logic [15:0] OP_WRITE_MASK    = 16'h0009;
  localparam logic [15:0] OP_COMPARE_STORE = 16'h001A;
  localparam logic [15:0] OP_INVALIDATE    = 16'h0022;
  localparam logic [15:0] OP_READ_ADDR     = 16'h1000;
  localparam logic [15:0] OP_INST_MASK     = 16'h103F;
  localparam logic [15:0] OP_RESET_VAL     = 16'h0003;
  // ----------------------------------------------------------------
  // Controller register map (AXI4-Lite byte offsets)
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CMD    = 8'h00;
  localparam logic [7:0] REG_WDATA  = 8'h04;
  localparam logic [7:0] REG_RDATA  = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam int CMD_GO_BIT    = 0;
  localparam int CMD_WRITE_BIT = 1;
  localparam int CMD_PHASE_BIT = 2;
  localparam int CMD_BCAST_BIT = 3;
  localparam int CMD_INDIV_BIT = 4;
  localparam int CMD_VALID_BIT = 5;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_VB_BIT   = 1;
  localparam logic [31:0] BAD_ADDR_DATA = 32'hDEAD_BEEF;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;
  // ----------------------------------------------------------------
  // Host sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {HOST_IDLE, HOST_STROBE, HOST_DONE} host_state_t;
endpackage

// file: logic/cam_link_if.sv
// Interface joining the host controller and the CAM device
`timescale 1ns/1ps
interface cam_link_if;
  logic        cycle;                 // One-cycle bus strobe
  logic        write;                 // Write when high
  logic        instruction_phase_n;   // Low: data cycle, high: load/status
  logic        broadcast_select_n;    // Broadcast chip select
  logic        individual_select_n;   // Individual chip select
  logic [31:0] data_bus_h2d;          // Host drive of data
  logic        validity_line_n_h2d;   // Host drive of validity
  logic [31:0] data_bus_d2h;          // Device read data
  logic        validity_line_n_d2h;   // Device read validity
  logic        data_oe_n;             // Low while device drives data
  modport host (output cycle, write, instruction_phase_n, broadcast_select_n,
                output individual_select_n, data_bus_h2d, validity_line_n_h2d,
                input data_bus_d2h, validity_line_n_d2h, data_oe_n);
  modport device (input cycle, write, instruction_phase_n, broadcast_select_n,
                  input individual_select_n, data_bus_h2d, validity_line_n_h2d,
                  output data_bus_d2h, validity_line_n_d2h, data_oe_n);
endinterface

// file: logic/cam_device.sv
// CAM device end: selection, instruction handling and validity bits
`timescale 1ns/1ps
module cam_device
  import cam_select_pkg::*;
(
  input  wire logic       SYS_CLK_I,
  input  wire logic       RST_N_I,
  input  wire logic [3:0] PAGE_ADDRESS_I,
  input  wire logic       DIAG_MODE_I,
  cam_link_if.device      link,
  output logic            MATCH_O,
  output logic [3:0]      MATCH_ADDR_O,
  output logic            FULL_O,
  output logic [3:0]      NEXT_FREE_O
);
  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [31:0] mem [DEPTH];          // Array words
  logic [DEPTH-1:0] empty;           // Validity, high = empty
  logic [15:0] instr;                // Persistent instruction
  logic [31:0] select_reg;           // Software select register
  logic [31:0] comparand;            // Comparand register
  logic [31:0] mask_reg;             // Single mask register
  logic [3:0]  addr_reg;             // Direct address register
  logic [3:0]  next_free;            // Encoder result, top empty
  logic        full;                 // No empty location left
  logic [DEPTH-1:0] hit;             // Per-location compare result
  logic        selected;             // Device takes this cycle
  logic        mem_access;           // Cycle touches array data
  logic        exec_cycle;           // Data cycle executing instr
  logic        load_cycle;           // Instruction load write
  logic [15:0] op;                   // Operation in force
  logic [3:0]  top_match;            // Highest-priority match
  logic        any_match;            // Any valid location hit
  logic [4:0]  pin_meta;             // First pin stage, may be metastable
  logic [4:0]  pin_sync;             // Settled {diag mode, page address}

  // ----------------------------------------------------------------
  // Pin synchroniser
  // ----------------------------------------------------------------
  // Mode pin and page strap come from outside; two flops before use
  always_ff @(posedge SYS_CLK_I) begin
    pin_meta <= {DIAG_MODE_I, PAGE_ADDRESS_I};
    pin_sync <= pin_meta;
  end

  // ----------------------------------------------------------------
  // Selection
  // ----------------------------------------------------------------
  // Pins win; register only when enabled and page matches
  assign selected = !link.broadcast_select_n || !link.individual_select_n
                  || (!select_reg[SEL_DISABLE_BIT]
                      && select_reg[3:0] == pin_sync[3:0]);
  assign load_cycle = link.cycle && selected && link.write && link.instruction_phase_n;
  assign exec_cycle = link.cycle && selected && !link.instruction_phase_n;
  // Op used now: a no-data instruction runs in its load cycle
  assign op = load_cycle ? link.data_bus_h2d[15:0] : instr;

  // ----------------------------------------------------------------
  // Priority encoders, lowest index is highest priority
  // ----------------------------------------------------------------
  always_comb begin
    next_free = '0;
    full      = 1'b1;
    top_match = '0;
    any_match = 1'b0;
    for (int i = DEPTH - 1; i >= 0; i--) begin
      if (empty[i]) begin
        next_free = ADDR_W'(i);
        full      = 1'b0;
      end
      if (hit[i]) begin
        top_match = ADDR_W'(i);
        any_match = 1'b1;
      end
    end
  end

  // Only valid locations may match; masked bits are ignored
  always_comb begin
    logic [31:0] key;
    logic [31:0] msk;
    key = (exec_cycle && instr[11:0] == OP_COMPARE_STORE[11:0]) ? link.data_bus_h2d
                                                                 : comparand;
    msk = (op[MASK_SEL_LSB +: 3] != 3'h0) ? mask_reg : '0;
    for (int i = 0; i < DEPTH; i++) begin
      hit[i] = !empty[i] && (((mem[i] ^ key) & ~msk) == '0);
    end
  end

  assign mem_access = (instr[11:0] == OP_WRITE_ADDR[11:0])
                   || (instr[11:0] == OP_WRITE_NEXT[11:0]);

  // ----------------------------------------------------------------
  // Instruction register
  // ----------------------------------------------------------------
  // Kept until a new load; each data cycle reruns it
  always_ff @(posedge SYS_CLK_I) begin
    if (!RST_N_I) begin
      instr <= OP_RESET_VAL;
    end else if (load_cycle) begin
      instr <= link.data_bus_h2d[15:0] & OP_INST_MASK;
    end
  end

  // ----------------------------------------------------------------
  // Registers written by data cycles
  // ----------------------------------------------------------------
  always_ff @(posedge SYS_CLK_I) begin
    if (!RST_N_I) begin
      select_reg <= SEL_RESET;
      comparand  <= '0;
      mask_reg   <= '0;
      addr_reg   <= '0;
    end else if (exec_cycle && link.write && !instr[READ_TYPE_BIT]) begin
      if (instr[11:0] == OP_WRITE_SELECT[11:0]) begin
        select_reg <= link.data_bus_h2d & SEL_MASK;
      end else if (instr[11:0] == OP_COMPARE_STORE[11:0]) begin
        comparand <= link.data_bus_h2d;
      end else if (instr[11:0] == OP_WRITE_MASK[11:0]) begin
        mask_reg <= link.data_bus_h2d;
      end else if (instr[11:0] == OP_WRITE_ADDRREG[11:0]) begin
        addr_reg <= link.data_bus_h2d[3:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Array and validity
  // ----------------------------------------------------------------
  // Validity line is a 33rd data bit for memory writes and for data-phase reads of the array, not of the select register
  always_ff @(posedge SYS_CLK_I) begin
    if (!RST_N_I) begin
      empty <= '1;
    end else if (exec_cycle && link.write && mem_access) begin
      if (instr[11:0] == OP_WRITE_NEXT[11:0]) begin
        if (!full) begin
          empty[next_free] <= link.validity_line_n_h2d;
        end
      end else begin
        empty[addr_reg] <= link.validity_line_n_h2d;
      end
    end else if (load_cycle && op[11:0] == OP_INVALIDATE[11:0] && MATCH_O) begin
      empty[MATCH_ADDR_O] <= 1'b1;
    end
  end

  // Data words carry no reset; validity guards them
  always_ff @(posedge SYS_CLK_I) begin
    if (exec_cycle && link.write && mem_access) begin
      if (instr[11:0] == OP_WRITE_NEXT[11:0]) begin
        if (!full) begin
          mem[next_free] <= link.data_bus_h2d;
        end
      end else begin
        mem[addr_reg] <= link.data_bus_h2d;
      end
    end
  end

  // ----------------------------------------------------------------
  // Match results, latched on compares
  // ----------------------------------------------------------------
  always_ff @(posedge SYS_CLK_I) begin
    if (!RST_N_I) begin
      MATCH_O      <= 1'b0;
      MATCH_ADDR_O <= '0;
    end else if ((exec_cycle && link.write && instr[11:0] == OP_COMPARE_STORE[11:0])
                 || (load_cycle && op[11:3] == 9'h003 && op[2:1] == 2'h0)) begin
      MATCH_O      <= any_match;
      MATCH_ADDR_O <= top_match;
    end
  end

  // Encoder results registered, so they trail the array by one cycle
  always_ff @(posedge SYS_CLK_I) begin
    if (!RST_N_I) begin
      FULL_O      <= 1'b0;
      NEXT_FREE_O <= '0;
    end else begin
      FULL_O      <= full;
      NEXT_FREE_O <= next_free;
    end
  end

  // ----------------------------------------------------------------
  // Read path, one cycle latency
  // ----------------------------------------------------------------
  always_ff @(posedge SYS_CLK_I) begin
    if (!RST_N_I) begin
      link.data_bus_d2h        <= '0;
      link.validity_line_n_d2h <= 1'b1;
      link.data_oe_n           <= 1'b1;
    end else if (link.cycle && selected && !link.write) begin
      link.data_oe_n <= 1'b0;
      if (link.instruction_phase_n) begin
        // Diagnostic mode exposes the instruction register
        link.data_bus_d2h <= pin_sync[4] ? {16'h0000, instr}
                                         : {26'h0, next_free, full, MATCH_O};
      end else if (instr[11:0] == OP_WRITE_SELECT[11:0]) begin
        link.data_bus_d2h <= select_reg;
      end else begin
        link.data_bus_d2h        <= mem[addr_reg];
        link.validity_line_n_d2h <= empty[addr_reg];
      end
    end else begin
      link.data_oe_n <= 1'b1;
    end
  end
endmodule

// file: logic/cam_host.sv
// Host controller end: AXI4-Lite slave issuing single CAM bus cycles
`timescale 1ns/1ps
module cam_host
  import cam_select_pkg::*;
(
  input  wire logic        SYS_CLK_I,
  input  wire logic        RST_N_I,
  input  wire logic [7:0]  AWADDR_I,
  input  wire logic        AWVALID_I,
  output logic             AWREADY_O,
  input  wire logic [31:0] WDATA_I,
  input  wire logic [3:0]  WSTRB_I,
  input  wire logic        WVALID_I,
  output logic             WREADY_O,
  output logic [1:0]       BRESP_O,
  output logic             BVALID_O,
  input  wire logic        BREADY_I,
  input  wire logic [7:0]  ARADDR_I,
  input  wire logic        ARVALID_I,
  output logic             ARREADY_O,
  output logic [31:0]      RDATA_O,
  output logic [1:0]       RRESP_O,
  output logic             RVALID_O,
  input  wire logic        RREADY_I,
  cam_link_if.host         link
);
  // ----------------------------------------------------------------
  // Controller registers
  // ----------------------------------------------------------------
  logic [5:0]  cmd;          // Control bits of last command
  logic [31:0] wdata;        // Word to drive on the bus
  logic [31:0] rdata;        // Word captured from the device
  logic        rvb_n;        // Validity captured from device
  host_state_t state;        // Sequencer state
  logic        go;           // Command start
  logic        do_write;     // Both write channels present

  assign do_write  = AWVALID_I && WVALID_I && !BVALID_O;
  assign AWREADY_O = do_write;
  assign WREADY_O  = do_write;
  assign ARREADY_O = !RVALID_O;
  assign go = do_write && AWADDR_I == REG_CMD && WDATA_I[CMD_GO_BIT]
           && WSTRB_I[0] && state == HOST_IDLE;

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  // Host drives the validity line low for a command that starts a cycle (CMD_GO_BIT set, sequencer idle) with CMD_VALID_BIT set
  always_ff @(posedge SYS_CLK_I) begin
    if (!RST_N_I) begin
      cmd   <= '0;
      wdata <= '0;
    end else if (do_write) begin
      if (AWADDR_I == REG_CMD) begin
        cmd <= WDATA_I[5:0];
      end else if (AWADDR_I == REG_WDATA) begin
        wdata <= WDATA_I;
      end
    end
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (!RST_N_I) begin
      BVALID_O <= 1'b0;
      BRESP_O  <= RESP_OKAY;
    end else if (do_write) begin
      BVALID_O <= 1'b1;
      BRESP_O  <= (AWADDR_I == REG_CMD || AWADDR_I == REG_WDATA) ? RESP_OKAY
                                                                 : RESP_SLVERR;
    end else if (BREADY_I) begin
      BVALID_O <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Bus sequencer: strobe one cycle, capture answer next
  // ----------------------------------------------------------------
  always_ff @(posedge SYS_CLK_I) begin
    if (!RST_N_I) begin
      state <= HOST_IDLE;
      rdata <= '0;
      rvb_n <= 1'b1;
    end else begin
      case (state)
        HOST_IDLE: begin
          if (go) begin
            state <= HOST_STROBE;
          end
        end
        HOST_STROBE: begin
          state <= HOST_DONE;
        end
        default: begin
          if (!link.data_oe_n) begin
            rdata <= link.data_bus_d2h;
            rvb_n <= link.validity_line_n_d2h;
          end
          state <= HOST_IDLE;
        end
      endcase
    end
  end

  // Pins idle deselected; strobe one cycle. Software deselects
  // every device before other bus traffic.
  always_ff @(posedge SYS_CLK_I) begin
    if (!RST_N_I) begin
      link.cycle               <= 1'b0;
      link.write               <= 1'b0;
      link.instruction_phase_n <= 1'b1;
      link.broadcast_select_n  <= 1'b1;
      link.individual_select_n <= 1'b1;
      link.data_bus_h2d        <= '0;
      link.validity_line_n_h2d <= 1'b1;
    end else if (go) begin
      link.cycle               <= 1'b1;
      link.write               <= WDATA_I[CMD_WRITE_BIT];
      link.instruction_phase_n <= WDATA_I[CMD_PHASE_BIT];
      link.broadcast_select_n  <= !WDATA_I[CMD_BCAST_BIT];
      link.individual_select_n <= !WDATA_I[CMD_INDIV_BIT];
      link.data_bus_h2d        <= wdata;
      link.validity_line_n_h2d <= !WDATA_I[CMD_VALID_BIT];
    end else begin
      link.cycle               <= 1'b0;
      link.broadcast_select_n  <= 1'b1;
      link.individual_select_n <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Register reads
  // ----------------------------------------------------------------
  always_ff @(posedge SYS_CLK_I) begin
    if (!RST_N_I) begin
      RVALID_O <= 1'b0;
      RDATA_O  <= '0;
      RRESP_O  <= RESP_OKAY;
    end else if (ARVALID_I && !RVALID_O) begin
      RVALID_O <= 1'b1;
      RRESP_O  <= RESP_OKAY;
      if (ARADDR_I == REG_CMD) begin
        RDATA_O <= {26'h0, cmd};
      end else if (ARADDR_I == REG_WDATA) begin
        RDATA_O <= wdata;
      end else if (ARADDR_I == REG_RDATA) begin
        RDATA_O <= rdata;
      end else if (ARADDR_I == REG_STATUS) begin
        RDATA_O <= {30'h0, rvb_n, state != HOST_IDLE};
      end else begin
        RDATA_O <= BAD_ADDR_DATA;
        RRESP_O <= RESP_SLVERR;
      end
    end else if (RREADY_I) begin
      RVALID_O <= 1'b0;
    end
  end
endmodule

// file: sim/cam_link_properties.sv
// Concurrent checks on the link between the CAM host and device
`timescale 1ns/1ps
module cam_link_properties
  import cam_select_pkg::*;
#(parameter logic [3:0] PAGE = 4'h0)
(
  input wire logic        SYS_CLK_I,
  input wire logic        RST_N_I,
  input wire logic        cycle,
  input wire logic        write,
  input wire logic        instruction_phase_n,
  input wire logic        broadcast_select_n,
  input wire logic        individual_select_n,
  input wire logic [31:0] data_bus_h2d,
  input wire logic        validity_line_n_h2d,
  input wire logic [31:0] data_bus_d2h,
  input wire logic        validity_line_n_d2h,
  input wire logic        data_oe_n
);
  // ----------------------------------------------------------------
  // Shadow of the device's instruction and select registers
  // ----------------------------------------------------------------
  logic [15:0] instr_q;   // Last instruction loaded
  logic [31:0] sel_q;     // Last select register value
  logic        soft_sel;  // Software selection active
  logic        picked;    // Device takes this cycle
  assign soft_sel = !sel_q[SEL_DISABLE_BIT] && (sel_q[3:0] == PAGE);
  assign picked   = !broadcast_select_n || !individual_select_n || soft_sel;
  // Instruction shadow, loaded by selected writes with phase high
  always_ff @(posedge SYS_CLK_I) begin
    if (!RST_N_I) begin
      instr_q <= OP_RESET_VAL;
    end else if (cycle && write && picked && instruction_phase_n) begin
      instr_q <= data_bus_h2d[15:0];
    end
  end
  // Select shadow; reserved bits dropped as the device must
  always_ff @(posedge SYS_CLK_I) begin
    if (!RST_N_I) begin
      sel_q <= SEL_RESET;
    end else if (cycle && write && picked && !instruction_phase_n
                 && instr_q == OP_WRITE_SELECT) begin
      sel_q <= data_bus_h2d & SEL_MASK;
    end
  end
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (!RST_N_I);
  a_strobe_one_cycle: assert property (cycle |=> !cycle)
    else $error("bus strobe longer than one cycle");
  a_selects_with_strobe: assert property (!cycle |-> broadcast_select_n && individual_select_n)
    else $error("select pin low outside a bus strobe");
  a_reply_one_cycle: assert property (!data_oe_n |=> data_oe_n)
    else $error("device drives data longer than one cycle");
  a_reply_needs_read: assert property ($fell(data_oe_n) |-> $past(cycle && !write))
    else $error("device drove data without a read");
  a_broadcast_override: assert property (cycle && !write && !broadcast_select_n |=> !data_oe_n)
    else $error("broadcast read not answered");
  a_individual_select: assert property (cycle && !write && !individual_select_n |=> !data_oe_n)
    else $error("individual read not answered");
  a_soft_select: assert property (cycle && !write && broadcast_select_n && individual_select_n
    |=> data_oe_n == !$past(soft_sel))
    else $error("software selection answered wrongly");
  a_disable_blocks: assert property (cycle && broadcast_select_n && individual_select_n
    && sel_q[SEL_DISABLE_BIT] |=> data_oe_n)
    else $error("disabled device answered");
  a_select_readback: assert property (cycle && !write && !instruction_phase_n && picked
    && instr_q == OP_WRITE_SELECT |=> data_bus_d2h == sel_q)
    else $error("select register read back wrongly");
  c_soft_read: cover property (cycle && !write && soft_sel && broadcast_select_n);
  c_invalidate: cover property (cycle && instruction_phase_n && data_bus_h2d[15:0] == OP_INVALIDATE);
  c_select_load: cover property (cycle && write && !instruction_phase_n && instr_q == OP_WRITE_SELECT);
endmodule

// file: sim/tb_cam_device_select_validity.sv
// Self-checking bench for the CAM host and device pair
`timescale 1ns/1ps
module tb_cam_device_select_validity;
  import cam_select_pkg::*;
  // ----------------------------------------------------------------
  // Signals and stimulus table
  // ----------------------------------------------------------------
  localparam logic [3:0] PAGE = 4'h5;  // Page of the single device
  typedef struct packed {logic [7:0] c; logic [31:0] d; int rep; logic [31:0] e;
                  logic [31:0] k; logic [3:0] nf; int m;} row_t;
  logic        SYS_CLK_I = 1'b0;
  logic        RST_N_I = 1'b0;
  logic        DIAG_MODE_I = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, match, full;
  logic [1:0]  bresp, rresp, r;
  logic [31:0] rdata, rd;
  logic [3:0]  match_addr, next_free;
  int          fails = 0, num_checks = 0, replies = 0, rep;
  // Command, data, replies, expected data, data mask, next free, match (2 = skip)
  row_t rows[21] = '{
    '{8'h0F, 32'h1, 0, 32'h0, 32'h0, 4'h0, 0},
    '{8'h2B, 32'hA1, 0, 32'h0, 32'h0, 4'h1, 0},
    '{8'h2B, 32'hA2, 0, 32'h0, 32'h0, 4'h2, 0},
    '{8'h0D, 32'h0, 1, 32'h08, 32'h3F, 4'h2, 0},
    '{8'h0F, 32'h1A, 0, 32'h0, 32'h0, 4'h2, 0},
    '{8'h0B, 32'hA2, 0, 32'h0, 32'h0, 4'h2, 1},
    '{8'h0F, 32'h22, 0, 32'h0, 32'h0, 4'h1, 2},
    '{8'h0F, 32'h1A, 0, 32'h0, 32'h0, 4'h1, 2},
    '{8'h0B, 32'hA2, 0, 32'h0, 32'h0, 4'h1, 0},
    '{8'h0B, 32'hA1, 0, 32'h0, 32'h0, 4'h1, 1},
    '{8'h0F, 32'h8, 0, 32'h0, 32'h0, 4'h1, 1},
    '{8'h0B, 32'hFFFF_FE05, 0, 32'h0, 32'h0, 4'h1, 1},
    '{8'h01, 32'h0, 1, 32'h005, 32'hFFFF_FFFF, 4'h1, 1},
    '{8'h03, 32'h106, 0, 32'h0, 32'h0, 4'h1, 1},
    '{8'h01, 32'h0, 0, 32'h0, 32'h0, 4'h1, 1},
    '{8'h09, 32'h0, 1, 32'h106, 32'hFFFF_FFFF, 4'h1, 1},
    '{8'h11, 32'h0, 1, 32'h106, 32'hFFFF_FFFF, 4'h1, 1},
    '{8'h0B, 32'h004, 0, 32'h0, 32'h0, 4'h1, 1},
    '{8'h01, 32'h0, 0, 32'h0, 32'h0, 4'h1, 1},
    '{8'h0F, 32'h1000, 0, 32'h0, 32'h0, 4'h1, 1},
    '{8'h09, 32'h0, 1, 32'hA1, 32'hFFFF_FFFF, 4'h1, 1}};
  // Free-running 10 MHz clock
  always #50 SYS_CLK_I = ~SYS_CLK_I;
  // Counts cycles in which the device drives read data
  always @(posedge SYS_CLK_I) begin
    if (link.data_oe_n === 1'b0) replies++;
  end
  cam_link_if link();
  cam_host cam_host_i (.SYS_CLK_I(SYS_CLK_I), .RST_N_I(RST_N_I), .AWADDR_I(awaddr),
    .AWVALID_I(awvalid), .AWREADY_O(awready), .WDATA_I(wdata), .WSTRB_I(4'hF),
    .WVALID_I(wvalid), .WREADY_O(wready), .BRESP_O(bresp), .BVALID_O(bvalid),
    .BREADY_I(bready), .ARADDR_I(araddr), .ARVALID_I(arvalid), .ARREADY_O(arready),
    .RDATA_O(rdata), .RRESP_O(rresp), .RVALID_O(rvalid), .RREADY_I(rready), .link(link));
  cam_device cam_device_i (.SYS_CLK_I(SYS_CLK_I), .RST_N_I(RST_N_I),
    .PAGE_ADDRESS_I(PAGE), .DIAG_MODE_I(DIAG_MODE_I), .link(link), .MATCH_O(match),
    .MATCH_ADDR_O(match_addr), .FULL_O(full), .NEXT_FREE_O(next_free));
  cam_link_properties #(.PAGE(PAGE)) cam_link_properties_i (.SYS_CLK_I(SYS_CLK_I),
    .RST_N_I(RST_N_I), .cycle(link.cycle), .write(link.write),
    .instruction_phase_n(link.instruction_phase_n),
    .broadcast_select_n(link.broadcast_select_n),
    .individual_select_n(link.individual_select_n), .data_bus_h2d(link.data_bus_h2d),
    .validity_line_n_h2d(link.validity_line_n_h2d), .data_bus_d2h(link.data_bus_d2h),
    .validity_line_n_d2h(link.validity_line_n_d2h), .data_oe_n(link.data_oe_n));
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  // Address and data offered together; one edge first so no signal is set twice
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge SYS_CLK_I);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do @(posedge SYS_CLK_I); while (awready !== 1'b1 || wready !== 1'b1);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    do @(posedge SYS_CLK_I); while (bvalid !== 1'b1);
    bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] s);
    @(posedge SYS_CLK_I);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge SYS_CLK_I); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge SYS_CLK_I); while (rvalid !== 1'b1);
    rready <= 1'b0;
    d = rdata;
    s = rresp;
  endtask
  task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  // One link cycle: data first, then command, poll busy, fetch captured data
  task automatic cam_op(input logic [7:0] c, input logic [31:0] d, output logic [31:0] q,
                        output int n);
    int          n0;
    logic [31:0] s;
    n0 = replies;
    s = 32'h1;
    axi_wr(REG_WDATA, d);
    axi_wr(REG_CMD, {24'h0, c});
    for (int k = 0; k < 50 && s[STAT_BUSY_BIT] !== 1'b0; k++) axi_rd(REG_STATUS, s, r);
    check("busy", {31'h0, s[STAT_BUSY_BIT]}, 32'h0);
    axi_rd(REG_RDATA, q, r);
    n = replies - n0;
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // Watchdog: the whole run needs far fewer cycles than this
  initial begin
    repeat (8000) @(posedge SYS_CLK_I);
    fails++;
    print_verdict;
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (20) @(posedge SYS_CLK_I);
    RST_N_I <= 1'b1;
    for (int i = 0; i < 21; i++) begin
      cam_op(rows[i].c, rows[i].d, rd, rep);
      check("replies", 32'(rep), 32'(rows[i].rep));
      check("rdata", rd & rows[i].k, rows[i].e);
      check("next_free", {28'h0, next_free}, {28'h0, rows[i].nf});
      if (rows[i].m < 2) check("match", {31'h0, match}, 32'(rows[i].m));
      $display("test %0d done", i);
    end
    check("match_addr", {28'h0, match_addr}, 32'h0);
    axi_rd(REG_STATUS, rd, r);
    check("validity", {31'h0, rd[STAT_VB_BIT]}, 32'h0);
    // Diagnostic mode returns the loaded instruction
    DIAG_MODE_I <= 1'b1;
    cam_op(8'h0D, 32'h0, rd, rep);
    check("diag", rd & 32'hFFFF, {16'h0, OP_READ_ADDR});
    DIAG_MODE_I <= 1'b0;
    $display("test diag done");
    // Unmapped controller address is refused
    axi_rd(8'h10, rd, r);
    check("bad_resp", {30'h0, r}, {30'h0, RESP_SLVERR});
    check("bad_data", rd, BAD_ADDR_DATA);
    axi_wr(8'h10, 32'h0);
    check("bad_bresp", {30'h0, bresp}, {30'h0, RESP_SLVERR});
    $display("test unmapped done");
    // Second reset in mid run empties the array
    @(posedge SYS_CLK_I);
    RST_N_I <= 1'b0;
    repeat (3) @(posedge SYS_CLK_I);
    RST_N_I <= 1'b1;
    @(posedge SYS_CLK_I);
    check("next_free", {28'h0, next_free}, 32'h0);
    check("full", {31'h0, full}, 32'h0);
    cam_op(8'h0D, 32'h0, rd, rep);
    check("status", rd & 32'h3F, 32'h0);
    $display("test reset done");
    print_verdict;
  end
endmodule
